// ===== logic/pmb_host.sv
// Host end of the power-bus link: runs one transaction per request.
// Assumes the target never stretches the clock; no arbitration.
`timescale 1ns/1ps
module pmb_host
  import pmb_pkg::*;
#(
  parameter int QTR_CYC = QTR_FAST
)
(
  // Clock, reset, enable
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic en_i,
  // Request
  input wire logic req_i,
  input wire pmb_kind_t kind_i,
  input wire logic [6:0] addr_i,
  input wire logic [7:0] cmd_i,
  input wire logic [7:0] wdata_i,
  // Answer
  output logic busy_o,
  output logic done_o,
  output logic nack_o,
  output logic [7:0] rdata_o,
  // Serial link
  pmb_if.host bus
);

  typedef enum logic [2:0] {
    H_START = 3'h0,
    H_WRA = 3'h1,
    H_RDA = 3'h2,
    H_CMD = 3'h3,
    H_DATA = 3'h4,
    H_RD = 3'h5,
    H_STOP = 3'h6,
    H_END = 3'h7
  } pmb_hop_t;

  // Only listed frame shapes exist
  localparam pmb_hop_t SEQ [4][8] = '{
    '{H_START, H_WRA, H_CMD, H_DATA, H_STOP, H_END, H_END, H_END},
    '{H_START, H_WRA, H_CMD, H_STOP, H_END, H_END, H_END, H_END},
    '{H_START, H_WRA, H_CMD, H_START, H_RDA, H_RD, H_STOP, H_END},
    '{H_START, H_RDA, H_RD, H_STOP, H_END, H_END, H_END, H_END}};
  localparam int QW = $clog2(QTR_CYC);

  function automatic logic is_wr(input pmb_hop_t o);
    return o == H_WRA || o == H_RDA || o == H_CMD || o == H_DATA;
  endfunction

  pmb_kind_t kind_q;
  logic [6:0] addr_q;
  logic [7:0] cmd_q, wdata_q, sh_q, rdata_q;
  logic [2:0] idx_q;
  logic [1:0] phase_q, sda_sync_q;
  logic [3:0] bit_q;
  logic [QW-1:0] qcnt_q;
  logic busy_q, done_q, nack_q, abort_q, fin_q, scl_oe_q, sda_oe_q;

  // A refused byte is followed straight by the stop, not the rest of the frame
  wire pmb_hop_t op = fin_q ? H_STOP : SEQ[kind_q][idx_q];
  wire pmb_hop_t nop = (op == H_STOP) ? H_END : abort_q ? H_STOP : SEQ[kind_q][idx_q + 3'h1];
  wire logic [7:0] nbyte = (nop == H_WRA) ? {addr_q, 1'b0} :
    (nop == H_RDA) ? {addr_q, 1'b1} : (nop == H_CMD) ? cmd_q : wdata_q;
  wire logic nsda = (nop == H_STOP) | (is_wr(nop) & ~nbyte[7]);
  wire logic sda_s = sda_sync_q[1];
  wire logic in_byte = op != H_START && op != H_STOP;
  wire logic qtick = qcnt_q == QW'(QTR_CYC - 1);

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      kind_q <= K_WRITE;
      addr_q <= '0;
      cmd_q <= 8'h00;
      wdata_q <= 8'h00;
      sh_q <= 8'h00;
      rdata_q <= 8'h00;
      idx_q <= 3'h0;
      phase_q <= 2'h0;
      sda_sync_q <= 2'h3;
      bit_q <= 4'h0;
      qcnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      nack_q <= 1'b0;
      abort_q <= 1'b0;
      fin_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end
    else if (en_i)
    begin
      sda_sync_q <= {sda_sync_q[0], bus.sda};
      done_q <= 1'b0;
      if (!busy_q)
      begin
        if (req_i)
        begin
          busy_q <= 1'b1;
          kind_q <= kind_i;
          addr_q <= addr_i;
          cmd_q <= cmd_i;
          wdata_q <= wdata_i;
          idx_q <= 3'h0;
          phase_q <= 2'h0;
          bit_q <= 4'h0;
          qcnt_q <= '0;
          abort_q <= 1'b0;
          fin_q <= 1'b0;
          nack_q <= 1'b0;
        end
      end
      else if (!qtick)
      begin
        qcnt_q <= qcnt_q + QW'(1);
      end
      else
      begin
        qcnt_q <= '0;
        phase_q <= phase_q + 2'h1;
        unique case (phase_q)
          2'h0: scl_oe_q <= 1'b0;
          2'h1:
          begin
            if (op == H_START) sda_oe_q <= 1'b1;
            else if (op == H_STOP) sda_oe_q <= 1'b0;
            else if (bit_q == 4'h8 && is_wr(op) && sda_s)
            begin
              abort_q <= 1'b1;
              nack_q <= 1'b1;
            end
            else if (op == H_RD && bit_q != 4'h8) sh_q <= {sh_q[6:0], sda_s};
          end
          2'h2: scl_oe_q <= op != H_STOP;
          2'h3:
          begin
            if (in_byte && bit_q != 4'h8)
            begin
              bit_q <= bit_q + 4'h1;
              // Read data bits and the final not-acknowledge stay released
              if (bit_q == 4'h7) sda_oe_q <= 1'b0;
              else if (is_wr(op))
              begin
                sh_q <= {sh_q[6:0], 1'b0};
                sda_oe_q <= ~sh_q[6];
              end
            end
            else
            begin
              bit_q <= 4'h0;
              idx_q <= idx_q + 3'h1;
              fin_q <= abort_q;
              sh_q <= nbyte;
              sda_oe_q <= nsda;
              if (op == H_RD) rdata_q <= sh_q;
              if (nop == H_END)
              begin
                busy_q <= 1'b0;
                done_q <= 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

  assign bus.host_scl_oe = scl_oe_q;
  assign bus.host_sda_oe = sda_oe_q;
  assign busy_o = busy_q;
  assign done_o = done_q;
  assign nack_o = nack_q;
  assign rdata_o = rdata_q;

endmodule

// ===== logic/pmb_if.sv
// Two-wire link between host and target, open drain with pull-ups.
// Assumes released lines float high; enables mean pulling low.
`timescale 1ns/1ps
interface pmb_if;
  logic host_scl_oe;
  logic host_sda_oe;
  logic dev_sda_oe;
  wire logic scl;
  wire logic sda;

  assign scl = ~host_scl_oe;
  assign sda = ~(host_sda_oe | dev_sda_oe);

  modport host (output host_scl_oe, output host_sda_oe, input scl, input sda);
  modport dev (output dev_sda_oe, input scl, input sda);
endinterface

// ===== logic/pmb_pkg.sv
// Constants shared by the power-bus target and its host.
// Both ends assume one 200 MHz core clock.
package pmb_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_KHZ = 200000;
  localparam int STD_KHZ = 100;
  localparam int FAST_KHZ = 400;
  // Quarter bit, rounded up so the bit rate never exceeds the figure
  localparam int QTR_FAST = (CLK_KHZ + 4 * FAST_KHZ - 1) / (4 * FAST_KHZ);
  localparam int QTR_STD = (CLK_KHZ + 4 * STD_KHZ - 1) / (4 * STD_KHZ);

  // ****************************************
  // Addressing and commands
  // ****************************************
  localparam logic [2:0] ADDR_FIXED = 3'h1;
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_ON_OFF_CONFIG = 8'h02;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_WRITE_PROTECT = 8'h10;
  localparam logic [7:0] CMD_STORE_ALL = 8'h11;
  localparam logic [7:0] CMD_RESTORE_ALL = 8'h12;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] CMD_MFR_BASE = 8'hD0;
  localparam int MFR_NUM = 7;
  localparam logic [7:0] WP_ONLY_WP = 8'h80;
  localparam logic [7:0] WP_PLUS_OP = 8'h40;
  localparam logic [7:0] WP_PLUS_CFG = 8'h20;
  localparam logic [7:0] WP_NONE = 8'h00;

  // ****************************************
  // Reset values and fields
  // ****************************************
  localparam logic [7:0] OPERATION_RST = 8'h00;
  localparam logic [7:0] ON_OFF_RST = 8'h17;
  localparam logic [7:0] MFR_RST = 8'h00;
  localparam logic [7:0] UNSUP_DATA = 8'hFF;
  localparam int CML_BIT = 1;

  // ****************************************
  // Strap ratio, in thousandths, and code edges
  // ****************************************
  localparam int RATIO_W = 10;
  localparam logic [RATIO_W-1:0] RATIO_EDGE [15] = '{
    10'h01B, 10'h036, 10'h052, 10'h06F, 10'h08F, 10'h0B1, 10'h0D4, 10'h0F6,
    10'h118, 10'h13B, 10'h162, 10'h18B, 10'h1B6, 10'h1E5, 10'h215};

  typedef enum logic [1:0] {
    K_WRITE = 2'h0,
    K_SEND = 2'h1,
    K_READ = 2'h2,
    K_READ_PTR = 2'h3
  } pmb_kind_t;

  // Edges sit midway between neighbouring nominal ratios
  function automatic logic [3:0] strap_code(input logic [RATIO_W-1:0] r);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < 15; i++)
    begin
      if (r >= RATIO_EDGE[i])
      begin
        c = 4'(i + 1);
      end
    end
    return c;
  endfunction

endpackage

// ===== logic/pmb_target.sv
// Target end of the power-bus link with its command registers.
// Assumes the link lines and supply monitor are asynchronous to clock_i.
`timescale 1ns/1ps
module pmb_target
  import pmb_pkg::*;
(
  // Clock, reset, enable
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic en_i,
  // Supply monitor and strap ratio of regulator_output_pin divider
  input wire logic uvlo_ok_i,
  input wire logic [RATIO_W-1:0] strap_ratio_i,
  // Status events from the power stage
  input wire logic [15:0] fault_set_i,
  // Serial link
  pmb_if.dev bus,
  // Settings and state toward the power stage
  output logic [6:0] own_addr_o,
  output logic addr_valid_o,
  output logic [7:0] operation_o,
  output logic [7:0] on_off_config_o,
  output logic [7:0] write_protect_o,
  output logic [MFR_NUM-1:0][7:0] mfr_o,
  output logic [15:0] status_word_o,
  output logic alert_oe_o
);

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_ADDR = 4'h1,
    S_ACK_A = 4'h2,
    S_CMD = 4'h3,
    S_ACK_C = 4'h4,
    S_WDATA = 4'h5,
    S_ACK_W = 4'h6,
    S_RDATA = 4'h7,
    S_RACK = 4'h8
  } pmb_dev_state_t;

  pmb_dev_state_t state_q;
  logic [1:0] scl_sync_q, sda_sync_q, uvlo_sync_q;
  logic [RATIO_W-1:0] ratio_m_q, ratio_q;
  logic scl_q, sda_q, sda_oe_q, extra_q, mack_q, valid_q, alert_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q, ptr_q, op_q, cfg_q, wp_q, nvm_cfg_q;
  logic [6:0] addr_q;
  logic [MFR_NUM-1:0][7:0] mfr_q, nvm_mfr_q;
  logic [15:0] status_q, status_d;

  // ****************************************
  // Command decode
  // ****************************************
  function automatic logic is_mfr(input logic [7:0] c);
    return c >= CMD_MFR_BASE && c < CMD_MFR_BASE + 8'(MFR_NUM);
  endfunction

  function automatic logic is_rw(input logic [7:0] c);
    return is_mfr(c) || c == CMD_OPERATION || c == CMD_ON_OFF_CONFIG || c == CMD_WRITE_PROTECT;
  endfunction

  function automatic logic is_send(input logic [7:0] c);
    return c == CMD_CLEAR_FAULTS || c == CMD_STORE_ALL || c == CMD_RESTORE_ALL;
  endfunction

  // Protect levels: anything not listed locks everything but itself and clear faults
  function automatic logic wp_allows(input logic [7:0] c, input logic [7:0] wp);
    return wp == WP_NONE || c == CMD_WRITE_PROTECT || c == CMD_CLEAR_FAULTS ||
      (c == CMD_OPERATION && (wp == WP_PLUS_OP || wp == WP_PLUS_CFG)) ||
      (c == CMD_ON_OFF_CONFIG && wp == WP_PLUS_CFG);
  endfunction

  wire logic scl_s = scl_sync_q[1];
  wire logic sda_s = sda_sync_q[1];
  wire logic scl_rise = scl_s & ~scl_q;
  wire logic scl_fall = ~scl_s & scl_q;
  wire logic start_c = scl_s & scl_q & sda_q & ~sda_s;
  wire logic stop_c = scl_s & scl_q & ~sda_q & sda_s;
  wire logic byte_in = cnt_q == 4'h8;
  wire logic rx_state = state_q == S_ADDR || state_q == S_CMD || state_q == S_WDATA;
  wire logic cmd_done = scl_fall & state_q == S_CMD & byte_in;
  wire logic wr_done = scl_fall & state_q == S_WDATA & byte_in;
  wire logic rd_load = scl_fall & state_q == S_ACK_A & sh_q[0];
  wire logic [2:0] mfr_idx = 3'(ptr_q - CMD_MFR_BASE);
  wire logic wp_val_ok = sh_q == WP_NONE || sh_q == WP_ONLY_WP || sh_q == WP_PLUS_OP || sh_q == WP_PLUS_CFG;
  wire logic wr_ok = ~extra_q & is_rw(ptr_q) & wp_allows(ptr_q, wp_q) &
    (ptr_q != CMD_WRITE_PROTECT | wp_val_ok);
  wire logic do_write = wr_done & wr_ok;
  wire logic send_ok = is_send(sh_q) & wp_allows(sh_q, wp_q);
  wire logic do_clear = cmd_done & sh_q == CMD_CLEAR_FAULTS;
  wire logic do_store = cmd_done & send_ok & sh_q == CMD_STORE_ALL;
  wire logic do_restore = cmd_done & send_ok & sh_q == CMD_RESTORE_ALL;
  wire logic readable = is_rw(ptr_q) | ptr_q == CMD_STATUS_WORD;
  // Unknown or refused traffic only raises the flag
  wire logic cml_evt = (cmd_done & ~is_rw(sh_q) & sh_q != CMD_STATUS_WORD & ~send_ok &
    sh_q != CMD_CLEAR_FAULTS) | (wr_done & ~wr_ok) | (rd_load & ~readable);
  // Second read byte is the status word's high byte; other registers repeat theirs
  wire logic [7:0] rd_byte = (ptr_q == CMD_STATUS_WORD) ?
      ((state_q == S_RACK) ? status_q[15:8] : status_q[7:0]) :
    (ptr_q == CMD_OPERATION) ? op_q :
    (ptr_q == CMD_ON_OFF_CONFIG) ? cfg_q :
    (ptr_q == CMD_WRITE_PROTECT) ? wp_q :
    is_mfr(ptr_q) ? mfr_q[mfr_idx] : UNSUP_DATA;

  // ****************************************
  // Input synchronisers and strap capture
  // ****************************************
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      uvlo_sync_q <= 2'h0;
      ratio_m_q <= '0;
      ratio_q <= '0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else if (en_i)
    begin
      scl_sync_q <= {scl_sync_q[0], bus.scl};
      sda_sync_q <= {sda_sync_q[0], bus.sda};
      uvlo_sync_q <= {uvlo_sync_q[0], uvlo_ok_i};
      ratio_m_q <= strap_ratio_i;
      ratio_q <= ratio_m_q;
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      valid_q <= 1'b0;
      addr_q <= '0;
    end
    else if (en_i)
    begin
      if (!uvlo_sync_q[1])
      begin
        valid_q <= 1'b0;
      end
      else if (!valid_q)
      begin
        addr_q <= {ADDR_FIXED, strap_code(ratio_q)};
        valid_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // Link engine
  // ****************************************
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_q <= S_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      sda_oe_q <= 1'b0;
      ptr_q <= 8'h00;
      extra_q <= 1'b0;
      mack_q <= 1'b0;
    end
    else if (en_i)
    begin
      if (stop_c)
      begin
        state_q <= S_IDLE;
        sda_oe_q <= 1'b0;
      end
      else if (start_c)
      begin
        state_q <= S_ADDR;
        cnt_q <= 4'h0;
        sda_oe_q <= 1'b0;
      end
      else if (scl_rise)
      begin
        if (state_q == S_RACK)
        begin
          mack_q <= ~sda_s;
        end
        else if (rx_state || state_q == S_RDATA)
        begin
          cnt_q <= cnt_q + 4'h1;
          if (rx_state)
          begin
            sh_q <= {sh_q[6:0], sda_s};
          end
        end
      end
      else if (scl_fall)
      begin
        unique case (state_q)
          S_IDLE:
          begin
          end
          S_ADDR:
          begin
            if (byte_in)
            begin
              // Silent on a foreign or not yet known address
              state_q <= (valid_q && sh_q[7:1] == addr_q) ? S_ACK_A : S_IDLE;
              sda_oe_q <= valid_q && sh_q[7:1] == addr_q;
            end
          end
          S_ACK_A:
          begin
            cnt_q <= 4'h0;
            if (sh_q[0])
            begin
              state_q <= S_RDATA;
              sh_q <= rd_byte;
              sda_oe_q <= ~rd_byte[7];
            end
            else
            begin
              state_q <= S_CMD;
              sda_oe_q <= 1'b0;
            end
          end
          S_CMD:
          begin
            if (byte_in)
            begin
              ptr_q <= sh_q;
              state_q <= S_ACK_C;
              sda_oe_q <= 1'b1;
            end
          end
          S_ACK_C, S_ACK_W:
          begin
            state_q <= S_WDATA;
            extra_q <= state_q == S_ACK_W;
            cnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
          end
          S_WDATA:
          begin
            if (byte_in)
            begin
              state_q <= S_ACK_W;
              sda_oe_q <= 1'b1;
            end
          end
          S_RDATA:
          begin
            if (byte_in)
            begin
              state_q <= S_RACK;
              sda_oe_q <= 1'b0;
            end
            else
            begin
              sh_q <= {sh_q[6:0], 1'b0};
              sda_oe_q <= ~sh_q[6];
            end
          end
          S_RACK:
          begin
            cnt_q <= 4'h0;
            state_q <= mack_q ? S_RDATA : S_IDLE;
            sh_q <= rd_byte;
            sda_oe_q <= mack_q & ~rd_byte[7];
          end
          default:
          begin
            state_q <= S_IDLE;
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Command registers, backing store, status
  // ****************************************
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      op_q <= OPERATION_RST;
      cfg_q <= ON_OFF_RST;
      wp_q <= WP_NONE;
      mfr_q <= {MFR_NUM{MFR_RST}};
      nvm_cfg_q <= ON_OFF_RST;
      nvm_mfr_q <= {MFR_NUM{MFR_RST}};
    end
    else if (en_i)
    begin
      if (do_store)
      begin
        nvm_cfg_q <= cfg_q;
        nvm_mfr_q <= mfr_q;
      end
      if (do_restore)
      begin
        cfg_q <= nvm_cfg_q;
        mfr_q <= nvm_mfr_q;
      end
      if (do_write)
      begin
        if (ptr_q == CMD_OPERATION) op_q <= sh_q;
        if (ptr_q == CMD_ON_OFF_CONFIG) cfg_q <= sh_q;
        if (ptr_q == CMD_WRITE_PROTECT) wp_q <= sh_q;
        if (is_mfr(ptr_q)) mfr_q[mfr_idx] <= sh_q;
      end
    end
  end

  // New events win over a clear in the same cycle
  assign status_d = (do_clear ? 16'h0000 : status_q) | fault_set_i |
    (16'(cml_evt) << CML_BIT);

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      status_q <= 16'h0000;
      alert_q <= 1'b0;
    end
    else if (en_i)
    begin
      status_q <= status_d;
      alert_q <= |status_d;
    end
  end

  assign bus.dev_sda_oe = sda_oe_q;
  assign own_addr_o = addr_q;
  assign addr_valid_o = valid_q;
  assign operation_o = op_q;
  assign on_off_config_o = cfg_q;
  assign write_protect_o = wp_q;
  assign mfr_o = mfr_q;
  assign status_word_o = status_q;
  assign alert_oe_o = alert_q;

endmodule

// ===== verif/pmb_props.sv
// Checker of the two-wire link between host and target ends.
// Assumes both ends share clock_i and that QTR_CYC is 8 in the bench.
`timescale 1ns/1ps
module pmb_props (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Link signals
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  // ******
  // Clock rises since the last start
  // ******
  logic [7:0] bits_q;
  logic [7:0] bits_d;
  logic scl_q;
  logic sda_q;
  wire logic start_seen;

  assign start_seen = scl && scl_q && sda_q && !sda;
  assign bits_d = start_seen ? 8'h00 : bits_q + {7'h00, scl & ~scl_q};

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      bits_q <= 8'h00;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      bits_q <= bits_d;
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // ******
  // Link properties
  // ******
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $past(scl) && $rose(sda);
  endsequence

  AST_DEV_SCL_LOW: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("target data moved while clock high");
  AST_HOST_SR: assert property ($changed(host_sda_oe) && scl |-> !dev_sda_oe)
    else $error("host framed while target drove data");
  AST_ADDR_FREE: assert property (dev_sda_oe |-> bits_q >= 8'h08)
    else $error("target drove during address bits");
  AST_SCL_HIGH: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  AST_START: assert property (s_start |-> scl [*4] ##[1:20] !scl)
    else $error("start not followed by clock low");
  AST_ACK_HELD: assert property ($rose(scl) && dev_sda_oe |-> (scl && dev_sda_oe) [*8])
    else $error("target bit not held over clock high");
  AST_STOP_IDLE: assert property (s_stop |-> (!dev_sda_oe && !host_scl_oe) [*4])
    else $error("link not idle after stop");
  AST_NINE_BITS: assert property (s_stop |-> bits_q % 8'h09 == 8'h01)
    else $error("frame not whole nine bit units");
endmodule

// ===== verif/pmbus_slave_interface_tb.sv
// Bench of host and target joined over the two-wire link.
// Assumes the host carries each request; expectations come from the bench.
`timescale 1ns/1ps
module pmbus_slave_interface_tb
  import pmb_pkg::*;
;
  // ******
  // Stimulus and wiring
  // ******
  localparam logic [9:0] NOM [16] = '{10'h00D, 10'h029, 10'h044, 10'h060, 10'h07E, 10'h0A0, 10'h0C3,
    10'h0E5, 10'h107, 10'h129, 10'h14E, 10'h177, 10'h1A0, 10'h1CD, 10'h1FD, 10'h22D};
  localparam logic [9:0] CRN [5] = '{10'h000, 10'h01A, 10'h01B, 10'h215, 10'h3E8};
  localparam logic [7:0] WPS [3] = '{WP_ONLY_WP, WP_PLUS_OP, WP_PLUS_CFG};
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic uvlo = 1'b0;
  logic en = 1'b1;
  logic req = 1'b0;
  pmb_kind_t kind = K_WRITE;
  logic [6:0] addr = 7'h00;
  logic [7:0] cmd = 8'h00;
  logic [7:0] wd = 8'h00;
  logic [9:0] r = 10'h000;
  logic [15:0] fset = 16'h0000;
  logic [6:0] own_addr;
  logic addr_valid;
  logic [7:0] op;
  logic [7:0] cfg;
  logic [7:0] wp;
  logic [MFR_NUM-1:0][7:0] mfr;
  logic [15:0] status;
  logic alert;
  logic busy;
  logic done;
  logic nack;
  logic [7:0] rdata;
  logic [7:0] v;
  logic [7:0] eop;
  logic [7:0] ecfg;
  logic [7:0] mv [7];
  logic [6:0] dev;
  logic [15:0] b;
  int fails = 0;
  int checked = 0;
  int seed = 32'hcdf9;

  always #2.5 clock_i = ~clock_i;

  pmb_if u_pmb_if();
  pmb_target u_pmb_target(.clock_i(clock_i), .arst_n_i(arst_n_i), .en_i(en), .uvlo_ok_i(uvlo),
    .strap_ratio_i(r), .fault_set_i(fset), .bus(u_pmb_if.dev), .own_addr_o(own_addr),
    .addr_valid_o(addr_valid), .operation_o(op), .on_off_config_o(cfg), .write_protect_o(wp),
    .mfr_o(mfr), .status_word_o(status), .alert_oe_o(alert));
  pmb_host #(.QTR_CYC(8)) u_pmb_host(.clock_i(clock_i), .arst_n_i(arst_n_i), .en_i(en),
    .req_i(req), .kind_i(kind), .addr_i(addr), .cmd_i(cmd), .wdata_i(wd), .busy_o(busy),
    .done_o(done), .nack_o(nack), .rdata_o(rdata), .bus(u_pmb_if.host));
  pmb_props u_pmb_props(.clock_i(clock_i), .arst_n_i(arst_n_i), .host_scl_oe(u_pmb_if.host_scl_oe),
    .host_sda_oe(u_pmb_if.host_sda_oe), .dev_sda_oe(u_pmb_if.dev_sda_oe), .scl(u_pmb_if.scl),
    .sda(u_pmb_if.sda));

  // ******
  // Helpers
  // ******
  // Edges halfway between neighbouring nominal ratios
  function automatic logic [3:0] exp_code(input logic [9:0] x);
    logic [3:0] c;
    c = 4'h0;
    for (int k = 0; k < 15; k++)
      if (2 * int'(x) + 1 >= int'(NOM[k]) + int'(NOM[k + 1]))
        c = 4'(k + 1);
    return c;
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic final_report();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Request taken at the rising edge between the two falling edges
  task automatic xfer(input pmb_kind_t k, input logic [6:0] a, input logic [7:0] c, input logic [7:0] d);
    int n;
    @(negedge clock_i);
    kind = k;
    addr = a;
    cmd = c;
    wd = d;
    req = 1'b1;
    @(negedge clock_i);
    req = 1'b0;
    chk("busy", 16'h0001, {15'h0000, busy});
    n = 0;
    while (n < 4000 && done !== 1'b1)
    begin
      @(negedge clock_i);
      n++;
    end
    chk("done", 16'h0001, {15'h0000, done});
    chk("idle", 16'h0000, {15'h0000, busy});
  endtask

  // ******
  // Scenarios
  // ******
  initial
  begin
    #400000;
    fails++;
    final_report();
  end

  initial
  begin
    repeat (16) @(negedge clock_i);
    arst_n_i = 1'b1;
    for (int i = 0; i < 9; i++)
    begin
      @(negedge clock_i);
      uvlo = 1'b0;
      r = (i < 5) ? CRN[i] : 10'($unsigned($random(seed)) % 1001);
      repeat (4) @(negedge clock_i);
      chk("addr_valid", 16'h0000, {15'h0000, addr_valid});
      uvlo = 1'b1;
      repeat (8) @(negedge clock_i);
      chk("addr_valid", 16'h0001, {15'h0000, addr_valid});
      chk("own_addr", {9'h000, ADDR_FIXED, exp_code(r)}, {9'h000, own_addr});
    end
    dev = {ADDR_FIXED, exp_code(r)};
    eop = 8'($random(seed));
    ecfg = ON_OFF_RST;
    xfer(K_WRITE, dev, CMD_OPERATION, eop);
    chk("operation", {8'h00, eop}, {8'h00, op});
    xfer(K_READ, dev, CMD_OPERATION, 8'h00);
    chk("read op", {8'h00, eop}, {8'h00, rdata});
    for (int i = 0; i < MFR_NUM; i++)
    begin
      mv[i] = 8'($random(seed));
      xfer(K_WRITE, dev, CMD_MFR_BASE + 8'(i), mv[i]);
      chk("mfr", {8'h00, mv[i]}, {8'h00, mfr[i]});
    end
    for (int i = 0; i < MFR_NUM; i++)
    begin
      xfer(K_SEND, dev, CMD_MFR_BASE + 8'(i), 8'h00);
      xfer(K_WRITE, dev ^ 7'h01, CMD_OPERATION, 8'h00);
      chk("foreign nack", 16'h0001, {15'h0000, nack});
      repeat (2)
      begin
        xfer(K_READ_PTR, dev, 8'h00, 8'h00);
        chk("ptr read", {8'h00, mv[i]}, {8'h00, rdata});
      end
    end
    xfer(K_WRITE, dev, 8'h55, 8'hA5);
    chk("unsup nack", 16'h0000, {15'h0000, nack});
    chk("unsup op", {8'h00, eop}, {8'h00, op});
    chk("cml", 16'h0001 << CML_BIT, status);
    chk("alert", 16'h0001, {15'h0000, alert});
    b = (16'h0001 << ($unsigned($random(seed)) % 16)) | (16'h0001 << CML_BIT);
    @(negedge clock_i);
    fset = b;
    @(negedge clock_i);
    fset = 16'h0000;
    xfer(K_READ, dev, CMD_STATUS_WORD, 8'h00);
    chk("status read", {8'h00, b[7:0]}, {8'h00, rdata});
    xfer(K_WRITE, dev, CMD_STATUS_WORD, 8'h00);
    chk("status ro", b, status);
    xfer(K_SEND, dev, CMD_CLEAR_FAULTS, 8'h00);
    chk("clear nack", 16'h0000, {15'h0000, nack});
    chk("cleared", 16'h0000, status);
    chk("alert off", 16'h0000, {15'h0000, alert});
    en = 1'b0;
    fset = 16'h0001;
    @(negedge clock_i);
    fset = 16'h0000;
    en = 1'b1;
    @(negedge clock_i);
    chk("frozen", 16'h0000, status);
    for (int i = 0; i < 3; i++)
    begin
      xfer(K_WRITE, dev, CMD_WRITE_PROTECT, WPS[i]);
      chk("wp", {8'h00, WPS[i]}, {8'h00, wp});
      v = 8'($random(seed)) | 8'h13;
      xfer(K_WRITE, dev, CMD_OPERATION, v);
      xfer(K_WRITE, dev, CMD_ON_OFF_CONFIG, v);
      eop = (WPS[i] != WP_ONLY_WP) ? v : eop;
      ecfg = (WPS[i] == WP_PLUS_CFG) ? v : ecfg;
      chk("wp op", {8'h00, eop}, {8'h00, op});
      chk("wp cfg", {8'h00, ecfg}, {8'h00, cfg});
    end
    xfer(K_WRITE, dev, CMD_WRITE_PROTECT, WP_NONE);
    chk("wp none", {8'h00, WP_NONE}, {8'h00, wp});
    xfer(K_SEND, dev, CMD_STORE_ALL, 8'h00);
    xfer(K_WRITE, dev, CMD_MFR_BASE, ~mv[0]);
    xfer(K_WRITE, dev, CMD_ON_OFF_CONFIG, ~ecfg | 8'h13);
    xfer(K_SEND, dev, CMD_RESTORE_ALL, 8'h00);
    chk("restore mfr", {8'h00, mv[0]}, {8'h00, mfr[0]});
    chk("restore cfg", {8'h00, ecfg}, {8'h00, cfg});
    final_report();
  end
endmodule
